// ===== design/dct_pkg.sv
/*
 * dct_pkg: shared constants and types of the dual counter/timer block.
 * Assumes an 8-bit register port and one 250 MHz system clock.
 */
package dct_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_RUN_FLAG = 4'h0;
   localparam logic [3:0] ADDR_MODE = 4'h1;
   localparam logic [3:0] ADDR_U0_LOW = 4'h2;
   localparam logic [3:0] ADDR_U0_HIGH = 4'h3;
   localparam logic [3:0] ADDR_U1_LOW = 4'h4;
   localparam logic [3:0] ADDR_U1_HIGH = 4'h5;
   localparam logic [3:0] ADDR_CLK_CFG = 4'h6;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
   localparam logic [3:0] ADDR_EXT_CFG = 4'h8;
   // run_and_flag_register fields
   localparam int BIT_TF1 = 7;
   localparam int BIT_TR1 = 6;
   localparam int BIT_TF0 = 5;
   localparam int BIT_TR0 = 4;
   // mode_select_register fields
   localparam int BIT_UNIT1_GATE_ENABLE = 7;
   localparam int BIT_CT1 = 6;
   localparam int POS_MODE1 = 4;
   localparam int BIT_UNIT0_GATE_ENABLE = 3;
   localparam int BIT_CT0 = 2;
   localparam int POS_MODE0 = 0;
   // timer_clock_config fields
   localparam int BIT_T1M = 3;
   localparam int BIT_T0M = 2;
   localparam int POS_SCA = 0;
   // interrupt_enable_register fields
   localparam int BIT_ET1 = 3;
   localparam int BIT_ET0 = 1;
   // ext_input_config fields
   localparam int BIT_POL_B = 7;
   localparam int BIT_POL_A = 3;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // operating modes
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // prescaler divisions
   localparam logic [3:0] DIV_12 = 4'hC;
   localparam logic [3:0] DIV_4 = 4'h4;
   localparam logic [2:0] EXT_DIV_LAST = 3'h7;
   localparam logic [1:0] SCA_EXT = 2'h3;
   localparam logic [1:0] SCA_DIV12 = 2'h0;

   // one register port access
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dct_bus_req_t;

   // result of one count step of a unit
   typedef struct packed {
      logic ovf;
      logic [7:0] low;
      logic [7:0] high;
   } dct_step_t;
endpackage

// ===== design/dct_timer.sv
/*
 * dct_timer: two counter/timers with four modes, prescaler, pin sync,
 * register port.
 * Assumes pins are sampled on ref_clk; reads answer one cycle later.
 */
// The placing of the registers and the plain strobed port were left to the implementer.
// Summary of operation
// RULE1 - each unit holds 16-bit count as two bytes
// RULE2 - two mode bits per unit, independent
// RULE3 - mode 0 counts 13 bits, high plus low[4:0]
// RULE4 - mode 0 wrap sets overflow flag
// RULE5 - counter select counts falling pin edges
// RULE6 - else sysclk or prescaler tick by select
// RULE7 - count when run and gate condition holds
// RULE8 - run bit never clears or reloads count
// RULE9 - unit 1 gate b, unit 0 gate a
// RULE10 - mode 1 same but full 16 bits
// RULE11 - mode 2 low counts, reloads from high
// RULE12 - mode 3 low byte uses unit 0 controls
// RULE13 - mode 3 high byte: unit1 run, flag
// RULE14 - split mode: unit 1 no pins, no flag
// RULE15 - split mode: unit 1 runs unless mode 3
// RULE16 - interrupt only when enable bit set
// RULE17 - prescale: /12, /4, /4, external /8
// RULE18 - external levels held two clocks minimum
// RULE19 - inputs synchronised, edges found after sync
// RULE20 - software byte write beats count update
`timescale 1ns/10ps
module dct_timer
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire dct_pkg::dct_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic count_pin_a,
   input wire logic count_pin_b,
   input wire logic ext_gate_input_a,
   input wire logic ext_gate_input_b,
   input wire logic ext_clk,
   output logic unit0_irq,
   output logic unit1_irq,
   output logic unit0_overflow_pulse,
   output logic unit1_overflow_pulse
);

   // one count step of a unit in a given mode
   function automatic dct_pkg::dct_step_t count_step(input logic [1:0] mode,
      input logic [7:0] low, input logic [7:0] high);
      dct_pkg::dct_step_t r;
      logic [12:0] c13;
      logic [15:0] c16;
      r = {1'b0, low, high};
      c13 = {high, low[4:0]};
      c16 = {high, low};
      case (mode)
         dct_pkg::MODE_13BIT:
         begin
            c13 = c13 + 13'h0001; // RULE3
            r.ovf = (c13 == 13'h0000); // RULE4
            r.high = c13[12:5];
            r.low = {low[7:5], c13[4:0]};
         end
         dct_pkg::MODE_16BIT:
         begin
            c16 = c16 + 16'h0001; // RULE10
            r.ovf = (c16 == 16'h0000);
            r.high = c16[15:8];
            r.low = c16[7:0];
         end
         dct_pkg::MODE_RELOAD:
         begin
            r.ovf = (low == 8'hFF);
            r.low = r.ovf ? high : low + 8'h01; // RULE11
         end
         default:
         begin
            r.ovf = (low == 8'hFF);
            r.low = low + 8'h01; // RULE12
         end
      endcase
      return r;
   endfunction
   // gate open when gate disabled or input at chosen level
   function automatic logic gate_open(input logic gate_en, input logic level,
      input logic pol);
      return !gate_en || (level == pol);
   endfunction

   logic [7:0] run_flag;
   logic [7:0] mode_reg;
   logic [7:0] u0_low;
   logic [7:0] u0_high;
   logic [7:0] u1_low;
   logic [7:0] u1_high;
   logic [7:0] clk_cfg;
   logic [7:0] irq_en;
   logic [7:0] ext_cfg;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [4:0] sync3;
   logic [3:0] pre_cnt;
   logic [2:0] ext_cnt;
   logic pre_tick;
   logic [1:0] mode0;
   logic [1:0] mode1;
   logic split;
   logic fall_a;
   logic fall_b;
   logic rise_ext;
   logic gate_a;
   logic gate_b;
   logic src0;
   logic src1;
   logic timer_src0;
   logic timer_src1;
   logic inc0;
   logic inc0_high;
   logic inc1;
   dct_pkg::dct_step_t step0;
   dct_pkg::dct_step_t step1;
   logic ovf0_high;
   logic set_tf0;
   logic set_tf1;
   logic wr_hit;

   // decoded fields
   assign mode0 = mode_reg[dct_pkg::POS_MODE0 +: 2]; // RULE2
   assign mode1 = mode_reg[dct_pkg::POS_MODE1 +: 2]; // RULE2
   assign split = (mode0 == dct_pkg::MODE_SPLIT);

   // two-stage synchronisers; stage one only feeds stage two
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         sync1 <= 5'h1F;
         sync2 <= 5'h1F;
         sync3 <= 5'h1F;
      end
      else
      begin
         sync1 <= {ext_clk, ext_gate_input_b, ext_gate_input_a, count_pin_b,
            count_pin_a}; // RULE19
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // edges taken on synchronised copies only
   assign fall_a = sync3[0] && !sync2[0]; // RULE19
   assign fall_b = sync3[1] && !sync2[1]; // RULE19
   assign gate_a = sync2[2];
   assign gate_b = sync2[3];
   assign rise_ext = !sync3[4] && sync2[4]; // RULE17

   // shared prescaler; tick is one ref_clk cycle wide
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pre_cnt <= 4'h0;
         ext_cnt <= 3'h0;
         pre_tick <= 1'b0;
      end
      else if (clk_cfg[dct_pkg::POS_SCA +: 2] == dct_pkg::SCA_EXT)
      begin
         pre_cnt <= 4'h0;
         if (rise_ext)
         begin
            ext_cnt <= ext_cnt + 3'h1;
         end
         pre_tick <= rise_ext && (ext_cnt == dct_pkg::EXT_DIV_LAST); // RULE17
      end
      else
      begin
         ext_cnt <= 3'h0;
         if (pre_cnt >= ((clk_cfg[dct_pkg::POS_SCA +: 2] == dct_pkg::SCA_DIV12) ?
            dct_pkg::DIV_12 - 4'h1 : dct_pkg::DIV_4 - 4'h1)) // RULE17
         begin
            pre_cnt <= 4'h0;
            pre_tick <= 1'b1;
         end
         else
         begin
            pre_cnt <= pre_cnt + 4'h1;
            pre_tick <= 1'b0;
         end
      end
   end

   // count sources per unit
   assign timer_src0 = clk_cfg[dct_pkg::BIT_T0M] ? 1'b1 : pre_tick; // RULE6
   assign timer_src1 = clk_cfg[dct_pkg::BIT_T1M] ? 1'b1 : pre_tick; // RULE6
   assign src0 = mode_reg[dct_pkg::BIT_CT0] ? fall_a : timer_src0; // RULE5
   // split mode takes the pin away from unit 1
   assign src1 = (mode_reg[dct_pkg::BIT_CT1] && !split) ? fall_b : timer_src1; // RULE14

   // enables; gate a serves unit 0, gate b unit 1
   assign inc0 = run_flag[dct_pkg::BIT_TR0] && src0 &&
      gate_open(mode_reg[dct_pkg::BIT_UNIT0_GATE_ENABLE], gate_a, ext_cfg[dct_pkg::BIT_POL_A]); // RULE7
   assign inc0_high = split && run_flag[dct_pkg::BIT_TR1] && timer_src0; // RULE13
   assign inc1 = split ? (mode1 != dct_pkg::MODE_SPLIT) && src1 // RULE15
      : run_flag[dct_pkg::BIT_TR1] && src1 && (mode1 != dct_pkg::MODE_SPLIT) &&
      gate_open(mode_reg[dct_pkg::BIT_UNIT1_GATE_ENABLE], gate_b, ext_cfg[dct_pkg::BIT_POL_B]); // RULE9

   assign step0 = count_step(mode0, u0_low, u0_high);
   assign step1 = count_step(mode1, u1_low, u1_high);
   assign ovf0_high = inc0_high && (u0_high == 8'hFF);
   assign set_tf0 = inc0 && step0.ovf;
   // in split mode only the borrowed high byte may raise flag 1
   assign set_tf1 = split ? ovf0_high : (inc1 && step1.ovf); // RULE14
   assign wr_hit = bus_req.wr;

   // unit 0 count bytes; software write wins over counting
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         u0_low <= dct_pkg::RESET_BYTE;
         u0_high <= dct_pkg::RESET_BYTE;
      end
      else
      begin
         if (wr_hit && bus_req.addr == dct_pkg::ADDR_U0_LOW)
         begin
            u0_low <= bus_req.wdata; // RULE20
         end
         else if (inc0)
         begin
            u0_low <= step0.low; // RULE1
         end
         if (wr_hit && bus_req.addr == dct_pkg::ADDR_U0_HIGH)
         begin
            u0_high <= bus_req.wdata; // RULE20
         end
         else if (inc0_high)
         begin
            u0_high <= u0_high + 8'h01; // RULE13
         end
         else if (inc0 && !split)
         begin
            u0_high <= step0.high; // RULE11
         end
      end
   end

   // unit 1 count bytes; counts even with flag blocked
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         u1_low <= dct_pkg::RESET_BYTE;
         u1_high <= dct_pkg::RESET_BYTE;
      end
      else
      begin
         if (wr_hit && bus_req.addr == dct_pkg::ADDR_U1_LOW)
         begin
            u1_low <= bus_req.wdata; // RULE20
         end
         else if (inc1)
         begin
            u1_low <= step1.low; // RULE1
         end
         if (wr_hit && bus_req.addr == dct_pkg::ADDR_U1_HIGH)
         begin
            u1_high <= bus_req.wdata; // RULE20
         end
         else if (inc1)
         begin
            u1_high <= step1.high; // RULE10
         end
      end
   end

   // run and flag bits; hardware set beats software clear
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         run_flag <= dct_pkg::RESET_BYTE;
      end
      else
      begin
         if (wr_hit && bus_req.addr == dct_pkg::ADDR_RUN_FLAG)
         begin
            run_flag <= {bus_req.wdata[7:4], 4'h0}; // RULE8
         end
         if (set_tf0)
         begin
            run_flag[dct_pkg::BIT_TF0] <= 1'b1; // RULE4
         end
         if (set_tf1)
         begin
            run_flag[dct_pkg::BIT_TF1] <= 1'b1; // RULE13
         end
      end
   end

   // configuration registers
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mode_reg <= dct_pkg::RESET_BYTE;
         clk_cfg <= dct_pkg::RESET_BYTE;
         irq_en <= dct_pkg::RESET_BYTE;
         ext_cfg <= dct_pkg::RESET_BYTE;
      end
      else if (wr_hit)
      begin
         case (bus_req.addr)
            dct_pkg::ADDR_MODE: mode_reg <= bus_req.wdata;
            dct_pkg::ADDR_CLK_CFG: clk_cfg <= {4'h0, bus_req.wdata[3:0]};
            dct_pkg::ADDR_IRQ_EN: irq_en <= bus_req.wdata;
            dct_pkg::ADDR_EXT_CFG: ext_cfg <= bus_req.wdata;
            default: mode_reg <= mode_reg;
         endcase
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         rdata <= 8'h00;
      end
      else if (bus_req.rd)
      begin
         case (bus_req.addr)
            dct_pkg::ADDR_RUN_FLAG: rdata <= run_flag;
            dct_pkg::ADDR_MODE: rdata <= mode_reg;
            dct_pkg::ADDR_U0_LOW: rdata <= u0_low; // RULE3
            dct_pkg::ADDR_U0_HIGH: rdata <= u0_high;
            dct_pkg::ADDR_U1_LOW: rdata <= u1_low;
            dct_pkg::ADDR_U1_HIGH: rdata <= u1_high;
            dct_pkg::ADDR_CLK_CFG: rdata <= clk_cfg;
            dct_pkg::ADDR_IRQ_EN: rdata <= irq_en;
            dct_pkg::ADDR_EXT_CFG: rdata <= ext_cfg;
            default: rdata <= 8'h00; // unmapped reads as zero
         endcase
      end
      else
      begin
         rdata <= 8'h00;
      end
   end

   // interrupt levels and overflow pulses, registered
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         unit0_irq <= 1'b0;
         unit1_irq <= 1'b0;
         unit0_overflow_pulse <= 1'b0;
         unit1_overflow_pulse <= 1'b0;
      end
      else
      begin
         unit0_irq <= run_flag[dct_pkg::BIT_TF0] && irq_en[dct_pkg::BIT_ET0]; // RULE16
         unit1_irq <= run_flag[dct_pkg::BIT_TF1] && irq_en[dct_pkg::BIT_ET1]; // RULE16
         unit0_overflow_pulse <= set_tf0;
         // stays usable by other peripherals in split mode
         unit1_overflow_pulse <= inc1 && step1.ovf; // RULE14
      end
   end
endmodule // dct_timer

// ===== tb/dct_pins_model.sv
/* dct_pins_model: count, gate and external clock pins of the timer.
   assumes the bench calls its tasks, timed by ref_clk. */
`timescale 1ns/10ps
module dct_pins_model
(
   input wire logic ref_clk,
   output logic [2:0] pins,
   output logic [1:0] gates
);
   // pins idle high so no false edge at start
   initial
   begin
      pins = 3'h7;
      gates = 2'h0;
   end
   // n low pulses on pin w; slow sources use a long hold
   task pulse(input int w, input int n, input int hold);
      repeat (n)
      begin
         repeat (hold) @(posedge ref_clk);
         pins[w] <= 1'b0;
         repeat (hold) @(posedge ref_clk);
         pins[w] <= 1'b1;
      end
      repeat (6) @(posedge ref_clk);
   endtask
   // gate levels change just after an edge
   task gate(input logic [1:0] g);
      @(posedge ref_clk);
      gates <= g;
   endtask
endmodule // dct_pins_model

// ===== tb/dct_timer_checker.sv
/* dct_timer_checker: port assertions for dct_timer, bound below.
   assumes the dct_pkg map and a one-cycle read answer. */
`timescale 1ns/10ps
module dct_timer_checker
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire dct_pkg::dct_bus_req_t bus_req,
   input wire logic [7:0] rdata,
   input wire logic unit0_irq,
   input wire logic unit1_irq,
   input wire logic unit0_overflow_pulse,
   input wire logic unit1_overflow_pulse
);
   logic [2:0] mir;
   logic wr_ctl;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // enable and run bits have no hardware writer, so a mirror is exact
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         mir <= 3'h0;
      else if (bus_req.wr && bus_req.addr == dct_pkg::ADDR_IRQ_EN)
         mir[1:0] <= {bus_req.wdata[dct_pkg::BIT_ET1], bus_req.wdata[dct_pkg::BIT_ET0]};
      else if (bus_req.wr && bus_req.addr == dct_pkg::ADDR_RUN_FLAG)
         mir[2] <= bus_req.wdata[dct_pkg::BIT_TR0];
   end
   // only flag or enable writes may drop an irq
   assign wr_ctl = bus_req.wr && (bus_req.addr == dct_pkg::ADDR_RUN_FLAG
      || bus_req.addr == dct_pkg::ADDR_IRQ_EN);
   chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data not zero outside answer");
   chk_unmapped_zero: assert property ($past(bus_req.rd && bus_req.addr > 4'h8)
      |-> rdata == 8'h00) else $error("unmapped read not zero");
   chk_flag_low_zero: assert property ($past(bus_req.rd && bus_req.addr == 4'h0)
      |-> rdata[3:0] == 4'h0) else $error("flag register low bits not zero");
   chk_irq0_enable: assert property (unit0_irq |-> $past(mir[0]))
      else $error("unit 0 irq without enable");
   chk_irq1_enable: assert property (unit1_irq |-> $past(mir[1]))
      else $error("unit 1 irq without enable");
   chk_irq0_hold: assert property ($fell(unit0_irq) |-> $past(wr_ctl, 2))
      else $error("unit 0 irq dropped by itself");
   chk_irq1_hold: assert property ($fell(unit1_irq) |-> $past(wr_ctl, 2))
      else $error("unit 1 irq dropped by itself");
   chk_pulse0_run: assert property (unit0_overflow_pulse |-> $past(mir[2])
      || $past(mir[2], 2)) else $error("unit 0 wrapped while stopped");
   cov_irq0: cover property (unit0_irq);
   cov_pulse1: cover property (unit1_overflow_pulse);
   cov_read: cover property ($past(bus_req.rd) && rdata != 8'h00);
endmodule // dct_timer_checker
bind dct_timer dct_timer_checker u_dct_timer_checker (.ref_clk, .srst, .bus_req, .rdata,
   .unit0_irq, .unit1_irq, .unit0_overflow_pulse, .unit1_overflow_pulse);

// ===== tb/dct_timer_tb.sv
/* dct_timer_tb: register tests of dct_timer against a pin model.
   assumes the dct_pkg map and a 250 MHz ref_clk. */
`timescale 1ns/10ps
module dct_timer_tb;
   logic ref_clk;
   logic srst;
   dct_pkg::dct_bus_req_t bus_req;
   logic [7:0] rdata;
   logic unit0_irq;
   logic unit1_irq;
   logic unit0_overflow_pulse;
   logic unit1_overflow_pulse;
   logic [2:0] pins;
   logic [1:0] gates;
   logic [7:0] v;
   int miscompares;
   int total_checks;
   int pulse0_seen = 0;
   int pulse1_seen = 0;
   int base;
   int dv [4] = '{1, 12, 4, 4};
   logic [7:0] cfg [4] = '{8'h04, 8'h00, 8'h01, 8'h02};
   dct_timer u_dct_timer (.ref_clk, .srst, .bus_req, .rdata, .count_pin_a(pins[0]),
      .count_pin_b(pins[1]), .ext_gate_input_a(gates[0]), .ext_gate_input_b(gates[1]),
      .ext_clk(pins[2]), .unit0_irq, .unit1_irq, .unit0_overflow_pulse,
      .unit1_overflow_pulse);
   dct_pins_model u_dct_pins_model (.ref_clk, .pins, .gates);
   // overflow pulses counted mid-cycle, where they have settled
   always @(negedge ref_clk)
   begin
      if (unit0_overflow_pulse === 1'b1)
         pulse0_seen <= pulse0_seen + 1;
      if (unit1_overflow_pulse === 1'b1)
         pulse1_seen <= pulse1_seen + 1;
   end
   // 4 ns system clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task results;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one-cycle strobes; a clock edge passes between accesses
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge ref_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task rc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      rd(a);
      cmp(v & m, e & m);
   endtask
   initial
   begin
      srst = 1'b1;
      bus_req = '0;
      miscompares = 0;
      total_checks = 0;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      for (int i = 0; i < 10; i++)
         rc(i < 9 ? 4'(i) : 4'hF, 8'h00, 8'hFF);
      // 13-bit wrap on pin a
      wr(dct_pkg::ADDR_IRQ_EN, 8'h0A);
      wr(dct_pkg::ADDR_MODE, 8'h04);
      wr(dct_pkg::ADDR_U0_HIGH, 8'hFF);
      wr(dct_pkg::ADDR_U0_LOW, 8'h1E);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h10);
      u_dct_pins_model.pulse(0, 2, 2);
      rc(dct_pkg::ADDR_U0_HIGH, 8'h00, 8'hFF);
      rc(dct_pkg::ADDR_U0_LOW, 8'h00, 8'h1F);
      rc(dct_pkg::ADDR_RUN_FLAG, 8'h30, 8'hF0);
      cmp({7'h00, unit0_irq}, 8'h01);
      cmp(8'(pulse0_seen), 8'h01);
      wr(dct_pkg::ADDR_IRQ_EN, 8'h08);
      repeat (2) @(posedge ref_clk);
      #1;
      cmp({7'h00, unit0_irq}, 8'h00);
      // stopped, resumed, then gated
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h00);
      u_dct_pins_model.pulse(0, 3, 3);
      rc(dct_pkg::ADDR_U0_LOW, 8'h00, 8'h1F);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h10);
      u_dct_pins_model.pulse(0, 3, 2);
      rc(dct_pkg::ADDR_U0_LOW, 8'h03, 8'h1F);
      wr(dct_pkg::ADDR_EXT_CFG, 8'h08);
      wr(dct_pkg::ADDR_MODE, 8'h0C);
      u_dct_pins_model.gate(2'b10);
      u_dct_pins_model.pulse(0, 2, 2);
      rc(dct_pkg::ADDR_U0_LOW, 8'h03, 8'h1F);
      u_dct_pins_model.gate(2'b01);
      u_dct_pins_model.pulse(0, 2, 2);
      rc(dct_pkg::ADDR_U0_LOW, 8'h05, 8'h1F);
      // unit 1 reload on pin b
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h00);
      wr(dct_pkg::ADDR_MODE, 8'h60);
      wr(dct_pkg::ADDR_U1_HIGH, 8'hF0);
      wr(dct_pkg::ADDR_U1_LOW, 8'hFE);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h40);
      u_dct_pins_model.pulse(1, 3, 2);
      rc(dct_pkg::ADDR_U1_LOW, 8'hF1, 8'hFF);
      rc(dct_pkg::ADDR_U1_HIGH, 8'hF0, 8'hFF);
      rc(dct_pkg::ADDR_RUN_FLAG, 8'hC0, 8'hF0);
      cmp({7'h00, unit1_irq}, 8'h01);
      // tick counts over a 98-cycle run; prescaler phase is free
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h00);
      wr(dct_pkg::ADDR_MODE, 8'h01);
      for (int k = 0; k < 4; k++)
      begin
         wr(dct_pkg::ADDR_CLK_CFG, cfg[k]);
         wr(dct_pkg::ADDR_U0_LOW, 8'h00);
         wr(dct_pkg::ADDR_RUN_FLAG, 8'h10);
         repeat (96) @(posedge ref_clk);
         wr(dct_pkg::ADDR_RUN_FLAG, 8'h00);
         rd(dct_pkg::ADDR_U0_LOW);
         cmp(8'(v >= 96 / dv[k] - 1 && v <= 99 / dv[k] + 1), 8'h01);
      end
      // external clock: 16 rising edges give two ticks
      wr(dct_pkg::ADDR_CLK_CFG, 8'h03);
      wr(dct_pkg::ADDR_U0_LOW, 8'h00);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h10);
      u_dct_pins_model.pulse(2, 16, 2);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h00);
      rc(dct_pkg::ADDR_U0_LOW, 8'h02, 8'hFF);
      // split: high byte runs on unit 1 run bit
      wr(dct_pkg::ADDR_CLK_CFG, 8'h04);
      wr(dct_pkg::ADDR_MODE, 8'h07);
      wr(dct_pkg::ADDR_U0_LOW, 8'h00);
      wr(dct_pkg::ADDR_U0_HIGH, 8'hF0);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h40);
      repeat (20) @(posedge ref_clk);
      rc(dct_pkg::ADDR_RUN_FLAG, 8'hC0, 8'hF0);
      rc(dct_pkg::ADDR_U0_LOW, 8'h00, 8'hFF);
      wr(dct_pkg::ADDR_RUN_FLAG, 8'h00);
      wr(dct_pkg::ADDR_CLK_CFG, 8'h08);
      wr(dct_pkg::ADDR_U1_HIGH, 8'hFF);
      wr(dct_pkg::ADDR_U1_LOW, 8'hF0);
      base = pulse1_seen;
      repeat (40) @(posedge ref_clk);
      rc(dct_pkg::ADDR_RUN_FLAG, 8'h00, 8'hF0);
      cmp(8'(pulse1_seen - base), 8'h01);
      // unit 1 halts in its own mode 3 while split
      wr(dct_pkg::ADDR_MODE, 8'h37);
      wr(dct_pkg::ADDR_U1_LOW, 8'h10);
      repeat (10) @(posedge ref_clk);
      rc(dct_pkg::ADDR_U1_LOW, 8'h10, 8'hFF);
      results();
   end
   // the tests take under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      $display("MISMATCH %0t watchdog expired", $time);
      results();
   end
endmodule // dct_timer_tb
